// ===== include/dma_cyc_pkg.sv
// shared constants for the dma descriptor cycle controller
// assumes a 32-bit descriptor layout: source end, destination end, control word
package dma_cyc_pkg;

  // ==========================================================
  // control word field layout
  localparam int MODE_LSB     = 0;
  localparam int MODE_W       = 3;
  localparam int N_LSB        = 4;
  localparam int N_W          = 10;
  localparam int RPOW_LSB     = 14;
  localparam int RPOW_W       = 4;
  localparam int SRC_SIZE_LSB = 24;
  localparam int SRC_INC_LSB  = 26;
  localparam int DST_SIZE_LSB = 28;
  localparam int DST_INC_LSB  = 30;
  localparam int FLD2_W       = 2;

  // ==========================================================
  // operating modes
  typedef enum logic [2:0] {
    MODE_STOP     = 3'b000,
    MODE_BASIC    = 3'b001,
    MODE_AUTO     = 3'b010,
    MODE_PINGPONG = 3'b011,
    MODE_MSG_PRI  = 3'b100,
    MODE_MSG_ALT  = 3'b101,
    MODE_PSG_PRI  = 3'b110,
    MODE_PSG_ALT  = 3'b111
  } mode_e;

  localparam logic [1:0] INC_NONE = 2'h3;

  // ==========================================================
  // descriptor word offsets inside a data structure
  localparam logic [31:0] DS_SRC_OFS = 32'h0000_0000;
  localparam logic [31:0] DS_DST_OFS = 32'h0000_0004;
  localparam logic [31:0] DS_CFG_OFS = 32'h0000_0008;

  // ==========================================================
  // register map
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_PRI_BASE = 12'h004;
  localparam logic [11:0] REG_ALT_BASE = 12'h008;
  localparam logic [11:0] REG_STATUS   = 12'h00c;

  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_SWREQ_BIT  = 1;
  localparam int CTRL_ALT_BIT    = 2;
  localparam int STAT_DONE_BIT   = 4;
  localparam int STAT_STOP_BIT   = 5;
  localparam int STAT_PEND_BIT   = 6;
  localparam int STAT_ALT_BIT    = 7;

  localparam logic [31:0] PRI_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] ALT_BASE_RST = 32'h0000_0100;

  localparam logic [10:0] MAX_INTERVAL = 11'h400;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_RD_SRC  = 4'b0001,
    S_RD_DST  = 4'b0010,
    S_RD_CFG  = 4'b0011,
    S_SETUP   = 4'b0100,
    S_RD_DATA = 4'b0101,
    S_WR_DATA = 4'b0110,
    S_WR_CFG  = 4'b0111
  } state_e;

endpackage

// ===== rtl/dma_addr_calc.sv
// transfer address from an end pointer, the remaining count and an increment code
// assumes inputs come from registers on the same clock; purely combinational
`timescale 1ns/10ps
module dma_addr_calc
  import dma_cyc_pkg::*;
(
  input  wire logic [31:0]    end_ptr,
  input  wire logic [N_W-1:0] count,
  input  wire logic [1:0]     inc,
  output logic      [31:0]    addr
);

  // ==========================================================
  // address arithmetic
  always_comb begin
    if (inc == INC_NONE) begin
      addr = end_ptr;
    end else begin
      // code 00 shifts by zero: byte stepping [R14]
      addr = end_ptr - ({22'h0, count} << inc); // [R12] [R13]
    end
  end

endmodule

// ===== rtl/dma_cycle_ctrl.sv
// single-channel dma descriptor cycle controller with apb configuration
// assumes a zero-latency-free memory port: mem_ack may come any cycle after mem_req
//
// Functional notes
// [R1] mode 000: structure invalid, no transfers
// [R2] basic mode waits fresh request each arbitration
// [R3] auto mode requests itself during arbitration
// [R4] ping-pong alternates primary and alternate structures
// [R5] alternate until invalid or mode changed; host refreshes
// [R6] memory scatter-gather: 100 primary, 101 alternate
// [R7] peripheral scatter-gather: 110 primary, 111 alternate
// [R8] fetch control word each cycle and interval
// [R9] write back control word after interval
// [R10] destination size forced equal to source size
// [R11] completion writes mode field to 000
// [R12] source address: end minus shifted count
// [R13] destination address: end minus shifted count
// [R14] increment 00 gives byte stepped addresses
// [R15] count field ten bits, transfers minus one
// [R16] count field updated before re-arbitration
// [R17] decrement count; zero-count transfer completes cycle
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module dma_cycle_ctrl
  import dma_cyc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dma_req,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [1:0]  mem_size,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             cycle_done
);

  // ==========================================================
  // declarations
  state_e           state_r;
  logic [31:0]      pri_base_r;
  logic [31:0]      alt_base_r;
  logic [31:0]      src_end_r;
  logic [31:0]      dst_end_r;
  logic [31:0]      cfg_r;
  logic [N_W-1:0]   cnt_r;
  logic [10:0]      burst_r;
  logic             complete_r;
  logic             en_r;
  logic             pend_r;
  logic             alt_r;
  logic             done_r;
  logic             stop_r;
  logic             req_s1_r;
  logic             req_s2_r;
  logic             req_s3_r;
  logic [31:0]      prdata_r;
  logic             mem_we_r;
  logic [31:0]      mem_addr_r;
  logic [31:0]      mem_wdata_r;
  logic             cycle_done_r;
  logic [31:0]      base;
  logic [31:0]      src_addr;
  logic [31:0]      dst_addr;
  logic [N_W-1:0]   cnt_nxt;
  logic             last_xfer;
  logic             interval_end;
  logic [31:0]      cfg_wb;
  logic             wr_take;
  logic             setup_take;
  logic             addr_ok;
  logic             req_edge;
  logic             take_req;
  logic             invalid_seen;
  logic             toggle_alt;
  mode_e            mode;

  // ==========================================================
  // helpers
  function automatic logic [10:0] interval_len(input logic [RPOW_W-1:0] rpow);
    if (rpow >= 4'd10) begin
      interval_len = MAX_INTERVAL;
    end else begin
      interval_len = 11'(11'h001 << rpow);
    end
  endfunction

  function automatic logic map_hit(input logic [11:0] a);
    map_hit = (a == REG_CTRL) || (a == REG_PRI_BASE) ||
              (a == REG_ALT_BASE) || (a == REG_STATUS);
  endfunction

  assign mode = mode_e'(cfg_r[MODE_LSB +: MODE_W]);
  assign base = alt_r ? alt_base_r : pri_base_r;

  // ==========================================================
  // address generation
  dma_addr_calc u_src_addr (
    .end_ptr (src_end_r),
    .count   (cnt_r),
    .inc     (cfg_r[SRC_INC_LSB +: FLD2_W]),
    .addr    (src_addr)
  );

  dma_addr_calc u_dst_addr (
    .end_ptr (dst_end_r),
    .count   (cnt_r),
    .inc     (cfg_r[DST_INC_LSB +: FLD2_W]),
    .addr    (dst_addr)
  );

  // ==========================================================
  // transfer bookkeeping
  assign last_xfer    = (cnt_r == '0); // [R17]
  assign cnt_nxt      = last_xfer ? cnt_r : cnt_r - 10'h001; // [R17]
  assign interval_end = last_xfer || (burst_r == 11'h001);

  always_comb begin
    cfg_wb = cfg_r;
    cfg_wb[N_LSB +: N_W] = cnt_nxt; // [R16]
    cfg_wb[DST_SIZE_LSB +: FLD2_W] = cfg_r[SRC_SIZE_LSB +: FLD2_W]; // [R10]
    if (last_xfer) begin
      cfg_wb[MODE_LSB +: MODE_W] = MODE_STOP; // [R11]
    end
  end

  // ==========================================================
  // apb slave, zero wait states
  assign pready     = 1'b1;
  assign addr_ok    = map_hit(paddr[11:0]) && (paddr[31:12] == 20'h0);
  assign pslverr    = psel && penable && !addr_ok;
  assign wr_take    = psel && penable && pwrite && addr_ok;
  assign setup_take = psel && !penable;
  assign prdata     = prdata_r;

  // read data captured in setup so it is stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (setup_take && !addr_ok) begin
      prdata_r <= 32'h0;
    end else if (setup_take) begin
      case (paddr[11:0])
        REG_CTRL:     prdata_r <= {29'h0, alt_r, 1'b0, en_r};
        REG_PRI_BASE: prdata_r <= pri_base_r;
        REG_ALT_BASE: prdata_r <= alt_base_r;
        REG_STATUS:   prdata_r <= {24'h0, alt_r, pend_r, stop_r, done_r, state_r};
        default:      prdata_r <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_base_r <= PRI_BASE_RST;
      alt_base_r <= ALT_BASE_RST;
    end else if (wr_take) begin
      if (paddr[11:0] == REG_PRI_BASE) begin
        pri_base_r <= pwdata;
      end
      if (paddr[11:0] == REG_ALT_BASE) begin
        alt_base_r <= pwdata;
      end
    end
  end

  // ==========================================================
  // channel enable and structure select
  assign invalid_seen = (state_r == S_RD_CFG) && mem_ack &&
                        (mem_rdata[MODE_LSB +: MODE_W] == MODE_STOP);
  // ping-pong and both scatter-gather pairs swap structures on completion
  assign toggle_alt   = (state_r == S_WR_CFG) && mem_ack && complete_r &&
                        (mode == MODE_PINGPONG || mode[2]); // [R4] [R6] [R7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
    end else if (invalid_seen) begin
      en_r <= 1'b0; // [R1] [R5]
    end else if (wr_take && paddr[11:0] == REG_CTRL) begin
      en_r <= pwdata[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_r <= 1'b0;
    end else if (toggle_alt) begin
      alt_r <= !alt_r; // [R4] [R5]
    end else if (wr_take && paddr[11:0] == REG_CTRL) begin
      alt_r <= pwdata[CTRL_ALT_BIT];
    end
  end

  // ==========================================================
  // request capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      req_s1_r <= dma_req;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  assign req_edge = req_s2_r && !req_s3_r;
  assign take_req = (state_r == S_IDLE) && en_r && pend_r;

  // a new request in the take cycle stays pending, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
    end else if (req_edge || (wr_take && paddr[11:0] == REG_CTRL && pwdata[CTRL_SWREQ_BIT])) begin
      pend_r <= 1'b1;
    end else if (take_req) begin
      pend_r <= 1'b0; // [R2]
    end
  end

  // ==========================================================
  // sticky status, write one to clear, hardware set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (toggle_alt || ((state_r == S_WR_CFG) && mem_ack && complete_r)) begin
      done_r <= 1'b1;
    end else if (wr_take && paddr[11:0] == REG_STATUS && pwdata[STAT_DONE_BIT]) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_r <= 1'b0;
    end else if (invalid_seen) begin
      stop_r <= 1'b1;
    end else if (wr_take && paddr[11:0] == REG_STATUS && pwdata[STAT_STOP_BIT]) begin
      stop_r <= 1'b0;
    end
  end

  // ==========================================================
  // descriptor sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= S_IDLE;
      src_end_r    <= 32'h0;
      dst_end_r    <= 32'h0;
      cfg_r        <= 32'h0;
      cnt_r        <= '0;
      burst_r      <= 11'h0;
      complete_r   <= 1'b0;
      mem_we_r     <= 1'b0;
      mem_addr_r   <= 32'h0;
      mem_wdata_r  <= 32'h0;
      cycle_done_r <= 1'b0;
    end else begin
      cycle_done_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (take_req) begin
            mem_we_r   <= 1'b0;
            mem_addr_r <= base + DS_SRC_OFS;
            state_r    <= S_RD_SRC;
          end
        end
        S_RD_SRC: begin
          if (mem_ack) begin
            src_end_r  <= mem_rdata;
            mem_addr_r <= base + DS_DST_OFS;
            state_r    <= S_RD_DST;
          end
        end
        S_RD_DST: begin
          if (mem_ack) begin
            dst_end_r  <= mem_rdata;
            mem_addr_r <= base + DS_CFG_OFS; // [R8]
            state_r    <= S_RD_CFG;
          end
        end
        S_RD_CFG: begin
          if (mem_ack) begin
            cfg_r      <= mem_rdata;
            cnt_r      <= mem_rdata[N_LSB +: N_W]; // [R15]
            burst_r    <= interval_len(mem_rdata[RPOW_LSB +: RPOW_W]);
            complete_r <= 1'b0;
            if (mem_rdata[MODE_LSB +: MODE_W] == MODE_STOP) begin
              state_r <= S_IDLE; // [R1]
            end else begin
              state_r <= S_SETUP;
            end
          end
        end
        S_SETUP: begin
          // one cycle for the address adders to see the fresh count
          mem_we_r   <= 1'b0;
          mem_addr_r <= src_addr; // [R12]
          state_r    <= S_RD_DATA;
        end
        S_RD_DATA: begin
          if (mem_ack) begin
            mem_we_r    <= 1'b1;
            mem_addr_r  <= dst_addr; // [R13]
            mem_wdata_r <= mem_rdata;
            state_r     <= S_WR_DATA;
          end
        end
        S_WR_DATA: begin
          if (mem_ack) begin
            cnt_r   <= cnt_nxt; // [R17]
            burst_r <= burst_r - 11'h001;
            if (interval_end) begin
              complete_r  <= last_xfer;
              // cfg_r keeps the fetched mode: the structure swap must still see it
              mem_we_r    <= 1'b1;
              mem_addr_r  <= base + DS_CFG_OFS;
              mem_wdata_r <= cfg_wb; // [R9] [R10] [R11]
              state_r     <= S_WR_CFG;
            end else begin
              state_r <= S_SETUP;
            end
          end
        end
        S_WR_CFG: begin
          if (mem_ack) begin
            mem_we_r <= 1'b0;
            if (complete_r) begin
              cycle_done_r <= 1'b1;
              state_r      <= S_IDLE; // [R4] [R5]
            end else if (mode == MODE_AUTO) begin
              // self-inserted request: re-enter arbitration without waiting
              mem_addr_r <= base + DS_SRC_OFS;
              state_r    <= S_RD_SRC; // [R3] [R8]
            end else begin
              state_r <= S_IDLE; // [R2]
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // memory port
  assign mem_req    = (state_r != S_IDLE) && (state_r != S_SETUP);
  assign mem_we     = mem_we_r;
  assign mem_addr   = mem_addr_r;
  assign mem_wdata  = mem_wdata_r;
  // source size serves both sides [R10]
  assign mem_size   = cfg_r[SRC_SIZE_LSB +: FLD2_W];
  assign cycle_done = cycle_done_r;

endmodule

// ===== verification/dma_cycle_checker.sv
// port assertions for the descriptor cycle controller
// assumes a bind onto dma_cycle_ctrl; one pclk domain
`timescale 1ns/10ps
module dma_cycle_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0]  mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        cycle_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // memory port
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
    && $stable(mem_wdata) && $stable(mem_size)) else $error("memory request changed before ack");
  fall_ack_a: assert property ($fell(mem_req) |-> $past(mem_ack)) else $error("request dropped unanswered");
  reset_quiet_a: assert property ($rose(presetn) |-> !mem_req && !cycle_done) else $error("busy after reset");
  // ==========================================================
  // completion
  done_wb_a: assert property (cycle_done |-> $past(mem_req && mem_ack && mem_we)
    && $past(mem_wdata[2:0]) == 3'b000) else $error("done without invalidating write-back");
  done_pulse_a: assert property (cycle_done |=> !cycle_done) else $error("done longer than one cycle");
  done_idle_a: assert property (cycle_done |-> !mem_req) else $error("memory busy at done");
  // ==========================================================
  // register bus
  ready_const_a: assert property (pready) else $error("wait state inserted");
  slverr_map_a: assert property (psel && penable |-> pslverr == !(paddr inside {32'h0, 32'h4, 32'h8, 32'hc}))
    else $error("error response wrong for address");
  unmapped_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  done_c: cover property (cycle_done);
  err_c: cover property (psel && penable && pslverr);
  slow_c: cover property ((mem_req && !mem_ack)[*2] ##1 mem_ack);
endmodule

bind dma_cycle_ctrl dma_cycle_checker dma_cycle_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata, .mem_ack, .cycle_done);

// ===== verification/dma_mem_model.sv
// word-wide system memory answering the controller's memory port
// assumes word storage only; ack_wait stretches every answer
`timescale 1ns/10ps
module dma_mem_model (
  input  wire logic        pclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  ack_wait,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] mem [0:1023];
  logic [32:0] log_q[$];
  logic [1:0]  wait_r;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wait_r = 2'h0;
  end
  // ==========================================================
  // answer, and log every completed access
  always @(posedge pclk) begin
    if (mem_req && mem_ack) begin
      log_q.push_back({mem_we, mem_addr});
      if (mem_we)
        mem[mem_addr[11:2]] = mem_wdata;
    end
    if (mem_req && !mem_ack && wait_r == ack_wait) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[11:2]];
      wait_r <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      // stale read data must not look valid
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        wait_r <= wait_r + 2'h1;
    end
  end
endmodule

// ===== verification/dma_cycle_ctrl_test.sv
// self-checking bench for the descriptor cycle controller
// assumes dma_mem_model as system memory; bench is the apb master
`timescale 1ns/10ps
module dma_cycle_ctrl_test
  import dma_cyc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, dma_req, err;
  logic [31:0] paddr, pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic        pready, pslverr, mem_req, mem_we, mem_ack, cycle_done;
  logic [1:0]  mem_size, ack_wait;
  int          bad_count, n_compared, done_cnt;

  dma_cycle_ctrl dma_cycle_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dma_req, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata, .mem_rdata, .mem_ack, .cycle_done);
  dma_mem_model dma_mem_model_i (.pclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .ack_wait, .mem_rdata, .mem_ack);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (cycle_done === 1'b1) done_cnt++;
  // ==========================================================
  // shared tasks
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      bad_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_log(input int n);
    int k;
    for (k = 0; k < 3000 && dma_mem_model_i.log_q.size() < n; k++) @(posedge pclk);
    if (k == 3000) begin
      bad_count++;
      wrap_up();
    end
    // done pulse lands one cycle after the last write-back
    repeat (4) @(posedge pclk);
  endtask
  task automatic check_log(input logic [32:0] e[$]);
    check(33'(dma_mem_model_i.log_q.size()), 33'(e.size()));
    foreach (e[i]) if (i < dma_mem_model_i.log_q.size()) check(dma_mem_model_i.log_q[i], e[i]);
    dma_mem_model_i.log_q.delete();
  endtask
  function automatic logic [31:0] cw(logic [2:0] m, logic [9:0] n, logic [3:0] r, logic [1:0] ss,
                                     logic [1:0] si, logic [1:0] ds, logic [1:0] di);
    return {di, ds, si, ss, 6'h0, r, n, 1'h0, m};
  endfunction
  task automatic put(input logic [31:0] b, input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
    dma_mem_model_i.mem[b[11:2]] = s;
    dma_mem_model_i.mem[b[11:2] + 10'h1] = d;
    dma_mem_model_i.mem[b[11:2] + 10'h2] = c;
    done_cnt = 0;
  endtask
  task automatic pulse_req;
    @(posedge pclk);
    dma_req <= 1'b1;
    repeat (4) @(posedge pclk);
    dma_req <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic test_regs;
    apb(1'b0, 32'(REG_PRI_BASE), 32'h0);
    check(rd, PRI_BASE_RST);
    apb(1'b0, 32'(REG_ALT_BASE), 32'h0);
    check(rd, ALT_BASE_RST);
    apb(1'b1, 32'h0000_0010, 32'h5);
    check(err, 1'b1);
    apb(1'b0, 32'h0000_0010, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b1, 32'(REG_CTRL), 32'h1);
    apb(1'b0, 32'(REG_CTRL), 32'h0);
    check(rd[2:0], 3'h1);
    $display("test regs done");
  endtask
  task automatic test_basic;
    put(32'h0, 32'h2ac, 32'h3ac, cw(MODE_BASIC, 10'h1, 4'h0, 2'h2, 2'h2, 2'h0, 2'h2));
    dma_mem_model_i.mem[32'h2a8 >> 2] = 32'h1234_5678;
    pulse_req();
    wait_log(6);
    check_log('{33'h8 - 33'h8, 33'h4, 33'h8, 33'h2a8, 33'h1000003a8, 33'h100000008});
    check(dma_mem_model_i.mem[2], cw(MODE_BASIC, 10'h0, 4'h0, 2'h2, 2'h2, 2'h2, 2'h2));
    check(dma_mem_model_i.mem[32'h3a8 >> 2], 32'h1234_5678);
    repeat (40) @(posedge pclk);
    check(33'(dma_mem_model_i.log_q.size()), 33'h0);
    check(33'(done_cnt), 33'h0);
    check(mem_size, 2'h2);
    pulse_req();
    wait_log(6);
    check_log('{33'h0, 33'h4, 33'h8, 33'h2ac, 33'h1000003ac, 33'h100000008});
    check(dma_mem_model_i.mem[2][2:0], MODE_STOP);
    check(32'(done_cnt), 32'h1);
    $display("test basic done");
  endtask
  task automatic test_auto;
    put(32'h0, 32'h1e7, 32'h2e7, cw(MODE_AUTO, 10'h3, 4'h1, 2'h0, 2'h0, 2'h0, 2'h0));
    apb(1'b1, 32'(REG_CTRL), 32'h3);
    wait_log(16);
    check_log('{33'h0, 33'h4, 33'h8, 33'h1e4, 33'h1000002e4, 33'h1e5, 33'h1000002e5, 33'h100000008,
      33'h0, 33'h4, 33'h8, 33'h1e6, 33'h1000002e6, 33'h1e7, 33'h1000002e7, 33'h100000008});
    check(dma_mem_model_i.mem[2], cw(MODE_STOP, 10'h0, 4'h1, 2'h0, 2'h0, 2'h0, 2'h0));
    check(32'(done_cnt), 32'h1);
    $display("test auto done");
  endtask
  task automatic test_pingpong;
    ack_wait <= 2'h2;
    put(32'h100, 32'h44, 32'h84, cw(MODE_PINGPONG, 10'h0, 4'h0, 2'h2, INC_NONE, 2'h2, INC_NONE));
    put(32'h0, 32'h40, 32'h80, cw(MODE_PINGPONG, 10'h0, 4'h0, 2'h2, INC_NONE, 2'h2, INC_NONE));
    apb(1'b1, 32'(REG_CTRL), 32'h3);
    wait_log(6);
    check_log('{33'h0, 33'h4, 33'h8, 33'h40, 33'h100000080, 33'h100000008});
    apb(1'b0, 32'(REG_STATUS), 32'h0);
    check(rd[STAT_ALT_BIT], 1'b1);
    // a plain request must run the other structure, software leaves alt alone
    pulse_req();
    wait_log(6);
    check_log('{33'h100, 33'h104, 33'h108, 33'h44, 33'h100000084, 33'h100000108});
    pulse_req();
    wait_log(3);
    repeat (20) @(posedge pclk);
    check_log('{33'h0, 33'h4, 33'h8});
    apb(1'b0, 32'(REG_CTRL), 32'h0);
    check(rd[CTRL_EN_BIT], 1'b0);
    apb(1'b0, 32'(REG_STATUS), 32'h0);
    check(rd[STAT_STOP_BIT], 1'b1);
    $display("test pingpong done");
  endtask
  task automatic sg_pair(input logic [2:0] pm, input logic [2:0] am);
    put(32'h100, 32'h48, 32'h88, cw(am, 10'h0, 4'h0, 2'h2, INC_NONE, 2'h2, INC_NONE));
    put(32'h0, 32'h4c, 32'h8c, cw(pm, 10'h0, 4'h0, 2'h2, INC_NONE, 2'h2, INC_NONE));
    apb(1'b1, 32'(REG_CTRL), 32'h3);
    wait_log(6);
    check_log('{33'h0, 33'h4, 33'h8, 33'h4c, 33'h10000008c, 33'h100000008});
    pulse_req();
    wait_log(6);
    check_log('{33'h100, 33'h104, 33'h108, 33'h48, 33'h100000088, 33'h100000108});
    check(32'(done_cnt), 32'h2);
  endtask
  task automatic test_gather;
    // scatter-gather codes only ever sit in their own structure
    sg_pair(MODE_MSG_PRI, MODE_MSG_ALT);
    sg_pair(MODE_PSG_PRI, MODE_PSG_ALT);
    $display("test gather done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, dma_req, presetn} = 5'h0;
    {paddr, pwdata, ack_wait} = 66'h0;
    bad_count = 0;
    n_compared = 0;
    done_cnt = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_basic();
    test_auto();
    test_pingpong();
    test_gather();
    wrap_up();
  end
endmodule
